//--- rtl/i2c_irq_threshold_clear.sv
`timescale 1ns/1ps
// Contract
// - Reading the data port with an empty receive buffer sets underflow bit 0.
// - When disabled, underflow holds until idle, then clears once internal enable drops.
// - Receive threshold is a 5-bit read/write field in bits 4:0, upper reserved.
// - Receive threshold N asserts receive-full at N plus one entries.
// - Receive threshold writes above buffer depth store the maximum depth.
// - Transmit threshold is a 5-bit read/write field in bits 4:0.
// - Transmit threshold 0 means 0 entries, 31 means 32 entries.
// - Transmit threshold writes above buffer depth store the maximum depth.
// - Clear-all read clears every software-clearable flag and every abort cause bit except bit 9.
// - Clear-all read leaves hardware-cleared threshold flags untouched.
// - Clear-all read spares abort cause bit 9.
// - Reading underrun clear register clears status bit 0.
// - Reading overrun clear register clears status bit 1.
// - Reading transmit overrun clear register clears status bit 3.
// - Reading read-request clear register clears status bit 5.
// - Receive-full clears at or below threshold and when disable flushes the buffer.
// - Transmit-empty clears when the level rises above threshold.
// - Both buffers are 32 entries deep, the clamp ceiling.

// How the block fits together.
// This block keeps the event flags of the two-wire controller that software clears by reading,
// together with the two fill thresholds that drive the level flags.
// The engines, the buffers and the enable register live elsewhere.
// They reach this block through the buffer levels, the set pulses, the enable levels and the idle level.
//
// Register bus timing.
// Every access takes one setup cycle and one enable cycle, and no wait state is ever inserted.
// Read data is snapshotted on the setup edge, so it stands through the whole enable cycle.
// It keeps standing until the next read setup.
// Writes and clearing reads act on the enable edge, when select and enable are both high.
// A clear register returns zero, so software learns nothing from the value it reads.
// The read itself is the command.
// Reserved bits and unmapped locations read zero; writes to unmapped locations have no effect, while a set reserved threshold bit clamps the write to 31.
//
// Flag timing.
// A sticky flag changes on the edge that samples its set or clear term.
// The status word is copied into a second register on the following edge.
// The status output therefore trails the flags by one cycle.
// The combined request output is registered beside that copy, so the two always agree.
// The level flags are registered once before the copy.
// A change of buffer level therefore shows on the status output one edge after the edge that samples it.
//
// Collisions.
// A set term beats a clear term on the same edge.
// An event that arrives just as software issues its clearing read is never lost.
// The cost is that software may see a flag it thought it had cleared.
// The same holds for the abort cause bits.
//
// Limitations.
// The clock enable gates every register, the read data snapshot included.
// The bus must not be used while it is low, because an access would then be dropped.
// Threshold writes are clamped rather than refused, so a read back shows what is in force.
// The level inputs must come from logic on this clock; they are not synchronised here.
module i2c_irq_threshold_clear (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic [31:0] PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [irq_thresh_pkg::REG_W-1:0] PWDATA,
   output logic [irq_thresh_pkg::REG_W-1:0] PRDATA,
   input wire logic DATA_CMD_RD,
   input wire logic [irq_thresh_pkg::LEVEL_W-1:0] RX_LEVEL,
   input wire logic [irq_thresh_pkg::LEVEL_W-1:0] TX_LEVEL,
   input wire logic ENABLE,
   input wire logic INTERNAL_ENABLE,
   input wire logic FSM_IDLE,
   input wire logic RX_OVER_SET,
   input wire logic TX_OVER_SET,
   input wire logic RD_REQ_SET,
   input wire logic ABORT_SET,
   input wire logic [irq_thresh_pkg::ABORT_W-1:0] ABORT_CAUSE_SET,
   output logic [irq_thresh_pkg::REG_W-1:0] RAW_STATUS,
   output logic [irq_thresh_pkg::ABORT_W-1:0] ABORT_CAUSE,
   output logic COMBINED_IRQ
);
   import irq_thresh_pkg::*;

   logic [FIELD_W-1:0] rx_thresh;
   logic [FIELD_W-1:0] tx_thresh;
   logic rd_access;
   logic wr_access;
   logic rd_clr_all;
   logic rd_clr_under;
   logic rd_clr_over;
   logic rd_clr_txover;
   logic rd_clr_rdreq;
   logic disable_drop;
   logic rx_under;
   logic rx_over;
   logic tx_over;
   logic rd_req;
   logic abort_flag;
   logic rx_full_r;
   logic rx_full_nxt;
   logic tx_empty_r;
   logic tx_empty_nxt;
   logic [ABORT_W-1:0] abort_cause_r;
   logic [ABORT_W-1:0] abort_cause_nxt;
   logic [ABORT_W-1:0] abort_clr_mask;
   logic [REG_W-1:0] status;
   logic [REG_W-1:0] rdata_r;
   logic [REG_W-1:0] rdata_nxt;
   logic [REG_W-1:0] status_r;
   // Named decode and clear terms, one per flag or register.
   logic wr_rx_thresh;
   logic wr_tx_thresh;
   logic setup_rd;
   logic rx_level_empty;
   logic under_set;
   logic under_clr;
   logic over_clr;
   logic txover_clr;
   logic rdreq_clr;
   logic abort_clr;
   logic combined_r;

   // Address match used by every decode term.
   function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
      hit = (a == target);
   endfunction : hit

   // Bus access phase; reads take effect once, in the enable phase.
   assign rd_access = PSEL && PENABLE && !PWRITE;
   assign wr_access = PSEL && PENABLE && PWRITE;
   assign rd_clr_all = rd_access && hit(PADDR, CLEAR_ALL_EVENTS_ADDR);
   assign rd_clr_under = rd_access && hit(PADDR, CLEAR_RECEIVE_UNDERRUN_ADDR);
   assign rd_clr_over = rd_access && hit(PADDR, CLEAR_RECEIVE_OVERRUN_ADDR);
   assign rd_clr_txover = rd_access && hit(PADDR, CLEAR_TRANSMIT_OVERRUN_ADDR);
   assign rd_clr_rdreq = rd_access && hit(PADDR, CLEAR_SLAVE_READ_REQUEST_ADDR);

   // Disabled flags keep their level until the engines are idle and enable falls.
   assign disable_drop = !ENABLE && FSM_IDLE && !INTERNAL_ENABLE;

   // Write strobes for the two threshold registers.
   // A write anywhere else, the read-only status word included, lands nowhere.
   assign wr_rx_thresh = wr_access && hit(PADDR, RECEIVE_FILL_THRESHOLD_ADDR);
   assign wr_tx_thresh = wr_access && hit(PADDR, TRANSMIT_FILL_THRESHOLD_ADDR);

   // Setup phase of a read.
   // Snapshotting here costs one register, but it keeps the read data a flip-flop output.
   assign setup_rd = PSEL && !PENABLE && !PWRITE;

   // Underflow set term.
   // A data port read that finds entries waiting is an ordinary pop, and it leaves the flag alone.
   assign rx_level_empty = (RX_LEVEL == '0);
   assign under_set = DATA_CMD_RD && rx_level_empty;

   // Clear terms of the flags that software clears.
   // The disable-idle drop covers underflow and the two overflows only.
   // A pending read request stays visible, since the remote master waits for it.
   // An abort stays visible until software issues the clear-all read.
   assign under_clr = rd_clr_under || rd_clr_all || disable_drop;
   assign over_clr = rd_clr_over || rd_clr_all || disable_drop;
   assign txover_clr = rd_clr_txover || rd_clr_all || disable_drop;
   assign rdreq_clr = rd_clr_rdreq || rd_clr_all;
   assign abort_clr = rd_clr_all;

   // Threshold registers with write clamping.
   threshold_reg u_rx_thresh (
      .MCLK(MCLK),
      .RST_N(RST_N),
      .ce(CE),
      .wr(wr_rx_thresh),
      .wdata(PWDATA),
      .value(rx_thresh)
   );

   threshold_reg u_tx_thresh (
      .MCLK(MCLK),
      .RST_N(RST_N),
      .ce(CE),
      .wr(wr_tx_thresh),
      .wdata(PWDATA),
      .value(tx_thresh)
   );

   // Receive underflow: a data port read with nothing buffered.
   sticky_flag u_rx_under (
      .MCLK(MCLK),
      .RST_N(RST_N),
      .ce(CE),
      .set(under_set),
      .clr(under_clr),
      .flag(rx_under)
   );

   // Receive overflow, set by the receive engine.
   sticky_flag u_rx_over (
      .MCLK(MCLK),
      .RST_N(RST_N),
      .ce(CE),
      .set(RX_OVER_SET),
      .clr(over_clr),
      .flag(rx_over)
   );

   // Transmit overflow, set by the command path.
   sticky_flag u_tx_over (
      .MCLK(MCLK),
      .RST_N(RST_N),
      .ce(CE),
      .set(TX_OVER_SET),
      .clr(txover_clr),
      .flag(tx_over)
   );

   // Slave read request.
   sticky_flag u_rd_req (
      .MCLK(MCLK),
      .RST_N(RST_N),
      .ce(CE),
      .set(RD_REQ_SET),
      .clr(rdreq_clr),
      .flag(rd_req)
   );

   // Transmit abort flag, cleared here only by the clear-all read.
   sticky_flag u_abort (
      .MCLK(MCLK),
      .RST_N(RST_N),
      .ce(CE),
      .set(ABORT_SET),
      .clr(abort_clr),
      .flag(abort_flag)
   );

   // Receive-full compares level against threshold plus one; a flushed buffer shows empty.
   assign rx_full_nxt = ENABLE && (RX_LEVEL >= ({1'b0, rx_thresh} + 6'h01));
   // Transmit-empty: threshold 31 reaches 32 entries; no activity while disabled drops it.
   assign tx_empty_nxt = (tx_thresh == THRESHOLD_MAX) ? (TX_LEVEL <= BUFFER_DEPTH)
                         : (TX_LEVEL <= {1'b0, tx_thresh});

   // Hardware-driven threshold flags, registered so status bits come from flip-flops.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rx_full_r <= 1'b0;
         tx_empty_r <= 1'b0;
      end else if (CE) begin
         rx_full_r <= rx_full_nxt;
         tx_empty_r <= tx_empty_nxt && (ENABLE || !FSM_IDLE);
      end
   end

   // Abort cause: bit 9 is spared by the clear; a new cause beats the clear.
   assign abort_clr_mask = rd_clr_all ? ~(16'h0001 << ABORT_KEEP_BIT) : 16'h0000;
   assign abort_cause_nxt = ABORT_CAUSE_SET | (abort_cause_r & ~abort_clr_mask);

   // Abort cause storage.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         abort_cause_r <= '0;
      end else if (CE) begin
         abort_cause_r <= abort_cause_nxt;
      end
   end

   // Raw status assembly; unused bits belong to other blocks and read zero here.
   always_comb begin
      status = STATUS_RESET;
      status[RX_UNDER_BIT] = rx_under;
      status[RX_OVER_BIT] = rx_over;
      status[RX_FULL_BIT] = rx_full_r;
      status[TX_OVER_BIT] = tx_over;
      status[TX_EMPTY_BIT] = tx_empty_r;
      status[RD_REQ_BIT] = rd_req;
      status[ABORT_BIT] = abort_flag;
   end

   // Read data mux; clear registers read zero, unmapped addresses read zero.
   assign rdata_nxt = hit(PADDR, RAW_EVENT_STATUS_ADDR) ? status
                    : hit(PADDR, RECEIVE_FILL_THRESHOLD_ADDR) ? {11'h000, rx_thresh}
                    : hit(PADDR, TRANSMIT_FILL_THRESHOLD_ADDR) ? {11'h000, tx_thresh}
                    : 16'h0000;

   // Read data is captured in the setup phase so it stands through the enable phase.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_r <= '0;
         status_r <= STATUS_RESET;
         combined_r <= 1'b0;
      end else if (CE) begin
         status_r <= status;
         combined_r <= |status;
         if (setup_rd) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   assign PRDATA = rdata_r;
   assign RAW_STATUS = status_r;
   assign ABORT_CAUSE = abort_cause_r;
   // The combined request is registered beside the status copy, so the two always agree.
   assign COMBINED_IRQ = combined_r;
endmodule : i2c_irq_threshold_clear

//--- rtl/irq_thresh_pkg.sv
package irq_thresh_pkg;
   // Register byte addresses on the peripheral bus.
   localparam logic [31:0] RAW_EVENT_STATUS_ADDR = 32'h50001534;
   localparam logic [31:0] RECEIVE_FILL_THRESHOLD_ADDR = 32'h50001538;
   localparam logic [31:0] TRANSMIT_FILL_THRESHOLD_ADDR = 32'h5000153c;
   localparam logic [31:0] CLEAR_ALL_EVENTS_ADDR = 32'h50001540;
   localparam logic [31:0] CLEAR_RECEIVE_UNDERRUN_ADDR = 32'h50001544;
   localparam logic [31:0] CLEAR_RECEIVE_OVERRUN_ADDR = 32'h50001548;
   localparam logic [31:0] CLEAR_TRANSMIT_OVERRUN_ADDR = 32'h5000154c;
   localparam logic [31:0] CLEAR_SLAVE_READ_REQUEST_ADDR = 32'h50001550;
   // Register and field geometry.
   localparam int REG_W = 16;
   localparam int FIELD_W = 5;
   localparam int LEVEL_W = 6;
   localparam logic [LEVEL_W-1:0] BUFFER_DEPTH = 6'h20;
   localparam logic [FIELD_W-1:0] THRESHOLD_MAX = 5'h1f;
   localparam logic [FIELD_W-1:0] THRESHOLD_RESET = 5'h00;
   // Bit positions in the raw event status register.
   localparam int RX_UNDER_BIT = 0;
   localparam int RX_OVER_BIT = 1;
   localparam int RX_FULL_BIT = 2;
   localparam int TX_OVER_BIT = 3;
   localparam int TX_EMPTY_BIT = 4;
   localparam int RD_REQ_BIT = 5;
   localparam int ABORT_BIT = 6;
   localparam int ABORT_KEEP_BIT = 9;
   localparam int ABORT_W = 16;
   localparam logic [REG_W-1:0] STATUS_RESET = 16'h0000;
endpackage : irq_thresh_pkg

//--- rtl/sticky_flag.sv
`timescale 1ns/1ps
// A sticky event flag: set wins over clear; any disable-idle drop comes in through clear.
module sticky_flag (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic ce,
   input wire logic set,
   input wire logic clr,
   output logic flag
);
   logic flag_r;
   logic flag_nxt;

   // A new event in the clearing cycle survives so it is not lost.
   assign flag_nxt = set ? 1'b1 : (clr ? 1'b0 : flag_r);
   assign flag = flag_r;

   // Flag storage.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         flag_r <= 1'b0;
      end else if (ce) begin
         flag_r <= flag_nxt;
      end
   end
endmodule : sticky_flag

//--- rtl/threshold_reg.sv
`timescale 1ns/1ps
// One 5-bit fill threshold register with write clamping to the buffer depth.
module threshold_reg (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic ce,
   input wire logic wr,
   input wire logic [irq_thresh_pkg::REG_W-1:0] wdata,
   output logic [irq_thresh_pkg::FIELD_W-1:0] value
);
   import irq_thresh_pkg::*;
   logic [FIELD_W-1:0] value_r;
   logic [FIELD_W-1:0] value_nxt;
   logic too_big;

   // The field cannot hold 32, so the deepest legal code stands in for any larger request.
   assign too_big = (wdata[REG_W-1:FIELD_W] != '0) || (wdata[FIELD_W-1:0] > THRESHOLD_MAX);
   assign value_nxt = too_big ? THRESHOLD_MAX : wdata[FIELD_W-1:0];
   assign value = value_r;

   // Stored threshold.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         value_r <= THRESHOLD_RESET;
      end else if (ce && wr) begin
         value_r <= value_nxt;
      end
   end
endmodule : threshold_reg

//--- tb/apb_sw_model.sv
`timescale 1ns/1ps
// Software on the peripheral bus: one setup and one enable cycle per access.
module apb_sw_model (
   input wire logic MCLK,
   input wire logic [15:0] PRDATA,
   output logic [31:0] PADDR,
   output logic PSEL,
   output logic PENABLE,
   output logic PWRITE,
   output logic [15:0] PWDATA
);
   initial {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
   // Released lines show the inverse so a stale value is never read as live.
   task xfer(input logic wr, input logic [31:0] a, input logic [15:0] wd, output logic [15:0] rd);
      @(posedge MCLK);
      {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, wr, a, wd};
      @(posedge MCLK);
      PENABLE <= 1'b1;
      @(posedge MCLK);
      rd = PRDATA;
      {PSEL, PENABLE, PADDR, PWDATA} <= {2'b00, ~a, ~wd};
   endtask : xfer
endmodule : apb_sw_model

//--- tb/irq_checker.sv
`timescale 1ns/1ps
// Port-level watcher; it mirrors the thresholds so the flags can be predicted.
module irq_checker (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic [31:0] PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [15:0] PWDATA,
   input wire logic [15:0] PRDATA,
   input wire logic DATA_CMD_RD,
   input wire logic [5:0] RX_LEVEL,
   input wire logic [5:0] TX_LEVEL,
   input wire logic ENABLE,
   input wire logic INTERNAL_ENABLE,
   input wire logic FSM_IDLE,
   input wire logic RX_OVER_SET,
   input wire logic TX_OVER_SET,
   input wire logic RD_REQ_SET,
   input wire logic ABORT_SET,
   input wire logic [15:0] ABORT_CAUSE_SET,
   input wire logic [15:0] RAW_STATUS,
   input wire logic [15:0] ABORT_CAUSE,
   input wire logic COMBINED_IRQ
);
   import irq_thresh_pkg::*;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N || !CE);
   logic [4:0] rx_thr_r;
   logic [4:0] tx_thr_r;
   // Decode of bus accesses and of the expected level flags.
   wire rd_take = PSEL && PENABLE && !PWRITE;
   wire wr_take = PSEL && PENABLE && PWRITE && CE;
   wire [4:0] wr_val = (|PWDATA[15:5]) ? THRESHOLD_MAX : PWDATA[4:0];
   wire any_set = DATA_CMD_RD | RX_OVER_SET | TX_OVER_SET | RD_REQ_SET | ABORT_SET | (|ABORT_CAUSE_SET);
   wire exp_rx = ENABLE && ({1'b0, RX_LEVEL} >= {2'h0, rx_thr_r} + 7'h01);
   wire exp_tx = (ENABLE || !FSM_IDLE) && ({1'b0, TX_LEVEL} <= {2'h0, tx_thr_r} + {6'h00, &tx_thr_r});
   wire [15:0] clr_m = (PADDR == CLEAR_RECEIVE_UNDERRUN_ADDR) ? 16'h0001 :
      (PADDR == CLEAR_RECEIVE_OVERRUN_ADDR) ? 16'h0002 : (PADDR == CLEAR_TRANSMIT_OVERRUN_ADDR) ? 16'h0008 :
      (PADDR == CLEAR_SLAVE_READ_REQUEST_ADDR) ? 16'h0020 : 16'h0000;
   // Shadow thresholds, clamped on write as the device must do.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rx_thr_r <= 5'h00;
         tx_thr_r <= 5'h00;
      end else if (wr_take && PADDR == RECEIVE_FILL_THRESHOLD_ADDR) begin
         rx_thr_r <= wr_val;
      end else if (wr_take && PADDR == TRANSMIT_FILL_THRESHOLD_ADDR) begin
         tx_thr_r <= wr_val;
      end
   end
   under_set_a: assert property (DATA_CMD_RD && RX_LEVEL == 6'h00 |-> ##2 RAW_STATUS[0])
      else $error("underflow not raised");
   disable_clr_a: assert property (!ENABLE && FSM_IDLE && !INTERNAL_ENABLE && !DATA_CMD_RD |-> ##2 !RAW_STATUS[0])
      else $error("underflow kept after idle disable");
   rx_full_a: assert property (RAW_STATUS[2] == $past(exp_rx, 2))
      else $error("receive-full flag wrong");
   tx_empty_a: assert property (RAW_STATUS[4] == $past(exp_tx, 2))
      else $error("transmit-empty flag wrong");
   thresh_read_a: assert property (rd_take && (PADDR == RECEIVE_FILL_THRESHOLD_ADDR || PADDR == TRANSMIT_FILL_THRESHOLD_ADDR)
      |-> PRDATA == {11'h000, (PADDR == RECEIVE_FILL_THRESHOLD_ADDR) ? rx_thr_r : tx_thr_r})
      else $error("threshold readback wrong");
   clear_all_a: assert property (rd_take && PADDR == CLEAR_ALL_EVENTS_ADDR && !any_set
      |-> ##2 (RAW_STATUS & 16'h006b) == 16'h0000 && (ABORT_CAUSE & 16'hfdff) == 16'h0000) else $error("clear-all missed");
   abort_keep_a: assert property (rd_take && PADDR == CLEAR_ALL_EVENTS_ADDR && ABORT_CAUSE[9] |-> ##2 ABORT_CAUSE[9])
      else $error("abort cause bit 9 lost");
   clear_one_a: assert property (rd_take && !any_set |-> ##2 (RAW_STATUS & $past(clr_m, 2)) == 16'h0000)
      else $error("dedicated clear missed");
   set_wins_a: assert property (rd_take && PADDR == CLEAR_RECEIVE_OVERRUN_ADDR && RX_OVER_SET |-> ##2 RAW_STATUS[1])
      else $error("new event lost to clear");
   combined_a: assert property (COMBINED_IRQ == |RAW_STATUS)
      else $error("combined output wrong");
endmodule : irq_checker

//--- tb/testbench.sv
`timescale 1ns/1ps
// Self-checking bench: a threshold table, then hand-written event cases.
module testbench;
   import irq_thresh_pkg::*;
   typedef struct {logic [15:0] wd; logic [5:0] rx; logic [5:0] tx; logic [15:0] rd; logic [15:0] st;} row_s;
   logic MCLK, RST_N, CE, DATA_CMD_RD, ENABLE, INTERNAL_ENABLE, FSM_IDLE, RX_OVER_SET, TX_OVER_SET, RD_REQ_SET;
   logic ABORT_SET, PSEL, PENABLE, PWRITE, COMBINED_IRQ;
   logic [5:0] RX_LEVEL, TX_LEVEL;
   logic [15:0] ABORT_CAUSE_SET, PWDATA, PRDATA, RAW_STATUS, ABORT_CAUSE, d, m;
   logic [31:0] PADDR;
   int bad_count, tests_run;
   row_s rows[8] = '{'{16'h0000, 6'h01, 6'h00, 16'h0000, 16'h0014}, '{16'h0000, 6'h00, 6'h01, 16'h0000, 16'h0000},
      '{16'h001f, 6'h1f, 6'h20, 16'h001f, 16'h0010}, '{16'h001e, 6'h1f, 6'h1f, 16'h001e, 16'h0004},
      '{16'h0020, 6'h20, 6'h1f, 16'h001f, 16'h0014}, '{16'hffff, 6'h1f, 6'h20, 16'h001f, 16'h0010},
      '{16'h0007, 6'h07, 6'h08, 16'h0007, 16'h0000}, '{16'h0007, 6'h08, 6'h07, 16'h0007, 16'h0014}};
   logic [31:0] clr_a[4] = '{CLEAR_RECEIVE_UNDERRUN_ADDR, CLEAR_RECEIVE_OVERRUN_ADDR, CLEAR_TRANSMIT_OVERRUN_ADDR,
      CLEAR_SLAVE_READ_REQUEST_ADDR};
   logic [15:0] clr_m[4] = '{16'h0001, 16'h0002, 16'h0008, 16'h0020};
   apb_sw_model sw (.*);
   i2c_irq_threshold_clear dut (.*);
   // Clock at 10 MHz.
   initial begin
      MCLK = 1'b0;
      forever #50 MCLK = ~MCLK;
   end
   task chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h, want %h", $time, g, e);
      end
   endtask : chk
   task rdchk(input logic [31:0] a, input logic [15:0] e);
      sw.xfer(1'b0, a, 16'h0000, d);
      chk(d, e);
   endtask : rdchk
   // One-cycle event pulses, then time for the status copy to follow.
   task ev(input logic [4:0] s, input logic [15:0] c);
      @(posedge MCLK);
      {ABORT_SET, RD_REQ_SET, TX_OVER_SET, RX_OVER_SET, DATA_CMD_RD, ABORT_CAUSE_SET} <= {s, c};
      @(posedge MCLK);
      {ABORT_SET, RD_REQ_SET, TX_OVER_SET, RX_OVER_SET, DATA_CMD_RD, ABORT_CAUSE_SET} <= '0;
      repeat (3) @(posedge MCLK);
   endtask : ev
   task test_done();
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   initial begin
      {RST_N, DATA_CMD_RD, ENABLE, INTERNAL_ENABLE, RX_OVER_SET, TX_OVER_SET, RD_REQ_SET, ABORT_SET} = '0;
      {CE, FSM_IDLE, RX_LEVEL, TX_LEVEL, ABORT_CAUSE_SET} = {2'b11, 28'h0};
      repeat (20) @(posedge MCLK);
      RST_N <= 1'b1;
      // Every register, then the first unmapped place, reads zero after reset.
      for (int i = 0; i < 9; i++) rdchk(RAW_EVENT_STATUS_ADDR + 32'(4 * i), 16'h0000);
      $display("reset test done");
      {ENABLE, INTERNAL_ENABLE} <= 2'b11;
      foreach (rows[i]) begin
         sw.xfer(1'b1, RECEIVE_FILL_THRESHOLD_ADDR, rows[i].wd, d);
         sw.xfer(1'b1, TRANSMIT_FILL_THRESHOLD_ADDR, rows[i].wd, d);
         {RX_LEVEL, TX_LEVEL} <= {rows[i].rx, rows[i].tx};
         repeat (3) @(posedge MCLK);
         chk(RAW_STATUS & 16'h0014, rows[i].st);
         rdchk(RECEIVE_FILL_THRESHOLD_ADDR, rows[i].rd);
         rdchk(TRANSMIT_FILL_THRESHOLD_ADDR, rows[i].rd);
      end
      $display("threshold table done");
      // A data read with entries waiting must not flag underflow.
      ev(5'b00001, 16'h0000);
      chk(RAW_STATUS & 16'h0001, 16'h0000);
      RX_LEVEL <= 6'h00;
      ev(5'b11111, 16'h0201);
      chk(RAW_STATUS & 16'h006b, 16'h006b);
      m = 16'h006b;
      foreach (clr_a[i]) begin
         sw.xfer(1'b0, clr_a[i], 16'h0000, d);
         m = m & ~clr_m[i];
         repeat (2) @(posedge MCLK);
         chk(RAW_STATUS & 16'h006b, m);
      end
      $display("dedicated clears done");
      ev(5'b01111, 16'h0000);
      sw.xfer(1'b0, CLEAR_ALL_EVENTS_ADDR, 16'h0000, d);
      repeat (2) @(posedge MCLK);
      chk(RAW_STATUS & 16'h007f, 16'h0010);
      chk(ABORT_CAUSE, 16'h0200);
      chk({15'h0000, COMBINED_IRQ}, 16'h0001);
      // An overrun arriving with its own clearing read must survive.
      fork
         sw.xfer(1'b0, CLEAR_RECEIVE_OVERRUN_ADDR, 16'h0000, d);
         begin
            repeat (2) @(posedge MCLK);
            RX_OVER_SET <= 1'b1;
            @(posedge MCLK);
            RX_OVER_SET <= 1'b0;
         end
      join
      repeat (2) @(posedge MCLK);
      chk(RAW_STATUS & 16'h0002, 16'h0002);
      $display("clear-all and collision done");
      // A set pulse while the clock enable is low must leave no trace.
      CE <= 1'b0;
      ev(5'b01000, 16'h0000);
      CE <= 1'b1;
      repeat (3) @(posedge MCLK);
      chk(RAW_STATUS & 16'h0020, 16'h0000);
      $display("clock enable test done");
      ev(5'b00001, 16'h0000);
      RX_LEVEL <= 6'h20;
      repeat (3) @(posedge MCLK);
      {ENABLE, FSM_IDLE} <= 2'b00;
      repeat (3) @(posedge MCLK);
      chk(RAW_STATUS & 16'h0007, 16'h0003);
      {FSM_IDLE, INTERNAL_ENABLE} <= 2'b10;
      repeat (3) @(posedge MCLK);
      chk(RAW_STATUS & 16'h0003, 16'h0000);
      $display("disable test done");
      test_done();
   end
endmodule : testbench
bind i2c_irq_threshold_clear irq_checker watch (.*);
